/* include/esf_pkg.sv */
// shared constants and types for the fast-scan packet framer
package esf_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] RATE_OFS   = 8'h04;
    localparam logic [7:0] BAUD_OFS   = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] CONF_OFS   = 8'h10;
    // control field positions
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_MODE_LSB = 8;
    localparam int CTRL_MODE_W   = 8;
    // status field positions
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_FMT_BIT    = 1;
    localparam int ST_LEGACY_BIT = 2;
    localparam int ST_COUNT_LSB  = 16;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] RATE_RST = 16'h0FA0;
    localparam logic [23:0] BAUD_RST = 24'h01_C200;
    // packet layout
    localparam logic [3:0] FIRST_SYNC_NIBBLE  = 4'hA;
    localparam logic [3:0] SECOND_SYNC_NIBBLE = 4'h5;
    localparam int HEAD_BYTES    = 4;
    localparam int ULTRA_CABINS  = 32;
    localparam int ULTRA_CBYTES  = 4;
    localparam int DENSE_CABINS  = 40;
    localparam int DENSE_CBYTES  = 2;
    localparam int ANGLE_W       = 15;
    localparam logic [14:0] ANGLE_LIMIT = 15'h5A00; // 360 * 64
    // bandwidth test: dense fits when rate * 21 <= baud and baud fits in 21 bits (2.1 byte, 10 bit)
    localparam logic [4:0] DENSE_BITS_X10 = 5'h15;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic {
        FMT_ULTRA,
        FMT_DENSE
    } esf_format_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] distance_mm;
        logic [11:0] major;
        logic [9:0]  first_predicted_sample;
        logic [9:0]  second_predicted_sample;
    } esf_sample_type;

    typedef struct packed {
        logic [14:0] reference_angle_fixed;
        logic        new_scan;
    } esf_angle_type;
endpackage : esf_pkg

/* rtl/esf_framer.sv */
// fast-scan packet framer with its sample fifo and avalon register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module esf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule : esf_fifo

module esf_framer (
    input  wire logic                    clock_i,
    input  wire logic                    reset_i,
    // avalon-mm slave
    input  wire logic [7:0]              avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o,
    // measurement stream
    input  wire logic                    sample_valid_i,
    output logic                         sample_ready_o,
    input  wire esf_pkg::esf_sample_type sample_i,
    // angle source, same clock
    input  wire esf_pkg::esf_angle_type  angle_i,
    // byte stream toward the uart
    output logic                         tx_valid_o,
    input  wire logic                    tx_ready_i,
    output logic      [7:0]              tx_data_o
);
    localparam int SW = $bits(esf_pkg::esf_sample_type);

    default clocking @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    typedef enum {
        ST_IDLE,
        ST_COLLECT,
        ST_SEND
    } esf_state_type;

    function automatic logic [7:0] byte_of(input logic [31:0] w,
                                           input logic [1:0]  lane);
        byte_of = w[lane*8 +: 8];
    endfunction : byte_of

    function automatic logic [7:0] xor_word(input logic [31:0] w);
        xor_word = w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24];
    endfunction : xor_word

    // registers
    logic [31:0]            ctrl_q;
    logic [15:0]            rate_q;
    logic [23:0]            baud_q;
    logic [15:0]            pkt_count_q;
    logic                   legacy_q;
    logic                   ack_q;
    logic [31:0]            rdata_q;
    // framer state
    esf_state_type          state_q;
    esf_pkg::esf_format_type fmt_q;
    esf_pkg::esf_format_type fmt_pick;
    logic [31:0]            cabin_q [esf_pkg::DENSE_CABINS];
    logic [5:0]             cnt_q;
    logic [7:0]             chk_q;
    logic [14:0]            angle_q;
    logic                   s_q;
    logic                   scan_pend_q;
    logic [7:0]             idx_q;
    logic [7:0]             out_idx_q;
    logic                   out_valid_q;
    logic [7:0]             out_data_q;
    // fifo side
    esf_pkg::esf_sample_type fifo_data;
    logic                   fifo_valid;
    logic                   fifo_pop;
    logic [31:0]            cabin_word;
    logic [5:0]             n_cabins;
    logic [7:0]             n_bytes;
    logic [7:0]             body_idx;
    logic [7:0]             next_byte;
    logic                   load;
    logic                   run;
    logic [7:0]             mode;
    logic [14:0]            angle_lim;
    logic [20:0]            need_bw;

    esf_fifo #(
        .WIDTH (SW),
        .DEPTH (esf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .in_data_i   (sample_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    assign run  = ctrl_q[esf_pkg::CTRL_RUN_BIT];
    assign mode = ctrl_q[esf_pkg::CTRL_MODE_LSB +: esf_pkg::CTRL_MODE_W];

    // dense packs 2.1 byte per sample, so it wins only when the link holds
    assign need_bw  = 21'(rate_q * esf_pkg::DENSE_BITS_X10);
    assign fmt_pick = (need_bw <= {3'h0, baud_q[20:0]} && baud_q[23:21] == 3'h0)
                    ? esf_pkg::FMT_DENSE : esf_pkg::FMT_ULTRA;

    // ---------------- avalon slave: answer one cycle after the request
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign avs_readdata_o    = rdata_q;

    always_ff @(posedge clock_i) begin
        if (reset_i)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_q <= esf_pkg::CTRL_RST;
            rate_q <= esf_pkg::RATE_RST;
            baud_q <= esf_pkg::BAUD_RST;
        end else if (avs_write_i && ack_q) begin
            case (avs_address_i)
                esf_pkg::CTRL_OFS: ctrl_q <= avs_writedata_i;
                esf_pkg::RATE_OFS: rate_q <= avs_writedata_i[15:0];
                esf_pkg::BAUD_OFS: baud_q <= avs_writedata_i[23:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            case (avs_address_i)
                esf_pkg::CTRL_OFS:   rdata_q <= ctrl_q;
                esf_pkg::RATE_OFS:   rdata_q <= {16'h0000, rate_q};
                esf_pkg::BAUD_OFS:   rdata_q <= {8'h00, baud_q};
                esf_pkg::STATUS_OFS: begin
                    rdata_q <= 32'h0000_0000;
                    rdata_q[esf_pkg::ST_ACTIVE_BIT] <= state_q != ST_IDLE;
                    rdata_q[esf_pkg::ST_FMT_BIT]    <= fmt_q;
                    rdata_q[esf_pkg::ST_LEGACY_BIT] <= legacy_q;
                    rdata_q[esf_pkg::ST_COUNT_LSB +: 16] <= pkt_count_q;
                end
                esf_pkg::CONF_OFS:   rdata_q <= {31'h0, fmt_pick};
                default:             rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------- cabin encoding
    always_comb begin
        cabin_word = 32'h0000_0000;
        if (fmt_q == esf_pkg::FMT_ULTRA) begin
            cabin_word = {fifo_data.second_predicted_sample,
                          fifo_data.first_predicted_sample,
                          fifo_data.major};
        end else if (fifo_data.valid) begin
            cabin_word = {16'h0000, fifo_data.distance_mm};
        end
    end

    assign n_cabins = (fmt_q == esf_pkg::FMT_ULTRA)
                    ? 6'(esf_pkg::ULTRA_CABINS)
                    : 6'(esf_pkg::DENSE_CABINS);
    assign n_bytes  = (fmt_q == esf_pkg::FMT_ULTRA)
                    ? 8'(esf_pkg::HEAD_BYTES
                         + esf_pkg::ULTRA_CABINS * esf_pkg::ULTRA_CBYTES)
                    : 8'(esf_pkg::HEAD_BYTES
                         + esf_pkg::DENSE_CABINS * esf_pkg::DENSE_CBYTES);
    assign fifo_pop = state_q == ST_COLLECT && fifo_valid;
    assign angle_lim = (angle_i.reference_angle_fixed >= esf_pkg::ANGLE_LIMIT)
                     ? angle_i.reference_angle_fixed - esf_pkg::ANGLE_LIMIT
                     : angle_i.reference_angle_fixed;

    // ---------------- sequencer
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q  <= ST_IDLE;
            fmt_q    <= esf_pkg::FMT_ULTRA;
            legacy_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // the legacy five-byte format is not served here
                    legacy_q <= run && mode == 8'h00;
                    if (run && mode != 8'h00) begin
                        state_q <= ST_COLLECT;
                        fmt_q   <= fmt_pick;
                    end
                end
                ST_COLLECT: begin
                    if (fifo_pop && cnt_q == n_cabins - 6'h01)
                        state_q <= ST_SEND;
                end
                ST_SEND: begin
                    if (load && idx_q == n_bytes - 8'h01) begin
                        state_q <= run ? ST_COLLECT : ST_IDLE;
                        fmt_q   <= fmt_pick;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ---------------- cabin store and checksum
    always_ff @(posedge clock_i) begin
        if (fifo_pop)
            cabin_q[cnt_q] <= cabin_word;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cnt_q   <= 6'h00;
            chk_q   <= 8'h00;
            angle_q <= 15'h0000;
            s_q     <= 1'b0;
        end else if (fifo_pop) begin
            if (cnt_q == 6'h00) begin
                // angle bytes count, sync bytes never do
                angle_q <= angle_lim;
                s_q     <= scan_pend_q || angle_i.new_scan;
                chk_q   <= xor_word(cabin_word) ^ angle_lim[7:0]
                         ^ {scan_pend_q || angle_i.new_scan,
                            angle_lim[14:8]};
            end else begin
                chk_q <= chk_q ^ xor_word(cabin_word);
            end
            cnt_q <= (cnt_q == n_cabins - 6'h01) ? 6'h00 : cnt_q + 6'h01;
        end
    end

    // a rotation mark between packets is held for the next one; a mark in the first-pop cycle goes straight into s_q and clears
    always_ff @(posedge clock_i) begin
        if (reset_i)
            scan_pend_q <= 1'b0;
        else if (state_q == ST_IDLE)
            scan_pend_q <= 1'b1;
        else if (angle_i.new_scan && !(fifo_pop && cnt_q == 6'h00))
            scan_pend_q <= 1'b1;
        else if (fifo_pop && cnt_q == 6'h00)
            scan_pend_q <= 1'b0;
    end

    // ---------------- byte emitter
    assign load     = state_q == ST_SEND && (!out_valid_q || tx_ready_i);
    assign body_idx = idx_q - 8'(esf_pkg::HEAD_BYTES);

    always_comb begin
        next_byte = 8'h00;
        case (idx_q)
            8'h00: next_byte = {esf_pkg::FIRST_SYNC_NIBBLE, chk_q[3:0]};
            8'h01: next_byte = {esf_pkg::SECOND_SYNC_NIBBLE, chk_q[7:4]};
            8'h02: next_byte = angle_q[7:0];
            8'h03: next_byte = {s_q, angle_q[14:8]};
            default: begin
                if (fmt_q == esf_pkg::FMT_ULTRA)
                    next_byte = byte_of(cabin_q[body_idx[7:2]], body_idx[1:0]);
                else
                    next_byte = byte_of(cabin_q[body_idx[6:1]],
                                        {1'b0, body_idx[0]});
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            out_valid_q <= 1'b0;
            out_data_q  <= 8'h00;
            out_idx_q   <= 8'h00;
            idx_q       <= 8'h00;
            pkt_count_q <= 16'h0000;
        end else begin
            if (load) begin
                out_valid_q <= 1'b1;
                out_data_q  <= next_byte;
                out_idx_q   <= idx_q;
                idx_q <= (idx_q == n_bytes - 8'h01) ? 8'h00 : idx_q + 8'h01;
                if (idx_q == n_bytes - 8'h01)
                    pkt_count_q <= pkt_count_q + 16'h0001;
            end else if (tx_ready_i) begin
                out_valid_q <= 1'b0;
            end
        end
    end

    assign tx_valid_o = out_valid_q;
    assign tx_data_o  = out_data_q;

    // assertions
    a_first_sync: assert property (
        out_valid_q && out_idx_q == 8'h00 |-> out_data_q[7:4] == 4'hA)
        else $error("first sync nibble wrong");
    a_second_sync: assert property (
        out_valid_q && out_idx_q == 8'h01 |-> out_data_q[7:4] == 4'h5)
        else $error("second sync nibble wrong");
    a_check_nibble: assert property (
        out_valid_q && out_idx_q == 8'h01 |-> out_data_q[3:0] == chk_q[7:4])
        else $error("check nibble does not match");
    a_ultra_count: assert property (
        state_q != ST_SEND && $past(state_q) == ST_SEND
        && $past(fmt_q) == esf_pkg::FMT_ULTRA |-> $past(idx_q) == 8'h83)
        else $error("ultra packet length wrong");
    a_dense_count: assert property (
        state_q == ST_SEND && $past(state_q) == ST_COLLECT
        && fmt_q == esf_pkg::FMT_DENSE |-> $past(cnt_q) == 6'h27)
        else $error("dense packet cabin count wrong");
    a_angle_range: assert property (
        angle_q < 15'h5A00)
        else $error("reference angle out of range");
    a_scan_flag: assert property (
        fifo_pop && cnt_q == 6'h00 && scan_pend_q |=> s_q)
        else $error("first packet lacks new scan flag");
    a_legacy_refuse: assert property (
        state_q == ST_IDLE && run && mode == 8'h00 |=> state_q == ST_IDLE)
        else $error("legacy mode started the framer");
    a_dense_invalid: assert property (
        fifo_pop && fmt_q == esf_pkg::FMT_DENSE && !fifo_data.valid
        |=> cabin_q[$past(cnt_q)] == 32'h0000_0000)
        else $error("invalid dense sample not zeroed");
endmodule : esf_framer

/* verif/esf_host_model.sv */
// host side model: receives packet bytes and checks sync and check field
`timescale 1ns/10ps

module esf_host_model (
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic [1:0] pace_i,
    input  wire logic [7:0] plen_i,
    output logic            tx_ready_o,
    output int              got_o,
    output int              good_o,
    output int              bad_o
);
    logic [7:0] cap [0:511];
    logic [7:0] hdr0_q;
    logic [7:0] hdr1_q;
    logic [7:0] xor_q;
    int         pos_q;
    logic [1:0] ph_q;

    // pace 0 prompt, 1 one byte in three, 2 stalled
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tx_ready_o <= 1'b0;
            ph_q       <= 2'h0;
        end else begin
            ph_q       <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            tx_ready_o <= (pace_i == 2'h0) || (pace_i == 2'h1 && ph_q == 2'h0);
        end
    end

    // length comes from the format the host asked about, as a real host does
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            got_o  <= 0;
            pos_q  <= 0;
            good_o <= 0;
            bad_o  <= 0;
            xor_q  <= 8'h00;
        end else if (tx_valid_i && tx_ready_o) begin
            cap[got_o] <= tx_data_i;
            got_o      <= got_o + 1;
            if (pos_q == 0) hdr0_q <= tx_data_i;
            if (pos_q == 1) hdr1_q <= tx_data_i;
            if (pos_q == int'(plen_i) - 1) begin
                pos_q <= 0;
                xor_q <= 8'h00;
                if (hdr0_q[7:4] == 4'hA && hdr1_q[7:4] == 4'h5 &&
                    {hdr1_q[3:0], hdr0_q[3:0]} == (xor_q ^ tx_data_i))
                    good_o <= good_o + 1;
                else
                    bad_o <= bad_o + 1;
            end else begin
                pos_q <= pos_q + 1;
                if (pos_q >= 2) xor_q <= xor_q ^ tx_data_i;
            end
        end
    end
endmodule : esf_host_model

/* verif/tb.sv */
// self-checking bench for the fast-scan packet framer
`timescale 1ns/10ps

`define ESF_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    err_total++; $display("BAD %0t got %0h exp %0h", $time, got, exp); end end

module tb;
    logic                   clock_i = 1'b0;
    logic                   reset_i = 1'b1;
    logic [7:0]             avs_address_i = 8'h00;
    logic                   avs_read_i = 1'b0;
    logic                   avs_write_i = 1'b0;
    logic [31:0]            avs_writedata_i = 32'h0;
    logic [31:0]            avs_readdata_o;
    logic                   avs_waitrequest_o;
    logic                   sample_valid_i = 1'b0;
    logic                   sample_ready_o;
    esf_pkg::esf_sample_type sample_i = '0;
    esf_pkg::esf_angle_type angle_i = '0;
    logic                   tx_valid_o;
    logic                   tx_ready_i;
    logic [7:0]             tx_data_o;
    logic [1:0]             pace = 2'h0;
    logic [7:0]             plen = 8'h54;
    int                     got;
    int                     good;
    int                     bad;
    int                     err_total = 0;
    int                     cmp_count = 0;
    logic [31:0]            rd;
    esf_pkg::esf_sample_type smp [0:63];

    always #2 clock_i = ~clock_i;

    esf_framer dut (.clock_i(clock_i), .reset_i(reset_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .sample_i(sample_i), .angle_i(angle_i), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o));

    esf_host_model host (.clock_i(clock_i), .reset_i(reset_i),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .pace_i(pace),
        .plen_i(plen), .tx_ready_o(tx_ready_i), .got_o(got),
        .good_o(good), .bad_o(bad));

    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // one idle edge after each access keeps strobes from being set twice
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clock_i);
    endtask : bus

    task automatic fill(input logic dense);
        for (int i = 0; i < 64; i++) begin
            smp[i].valid = dense ? (i != 5) : 1'b1;
            smp[i].distance_mm = 16'(i * 257 + 3);
            smp[i].major = 12'(i * 37 + 1);
            smp[i].first_predicted_sample = 10'(i * 5 + 2);
            smp[i].second_predicted_sample = 10'(i * 11 + 7);
        end
    endtask : fill

    task automatic feed(input int a, input int b);
        for (int i = a; i <= b; i++) begin
            sample_valid_i <= 1'b1;
            sample_i       <= smp[i];
            @(posedge clock_i);
            while (sample_ready_o !== 1'b1) @(posedge clock_i);
        end
        sample_valid_i <= 1'b0;
    endtask : feed

    task automatic wait_bytes(input int n);
        int t;
        t = 0;
        while (got < n && t < 8000) begin
            @(posedge clock_i);
            t++;
        end
        `ESF_CHK(got, n)
    endtask : wait_bytes

    task automatic check_pkt(input int at, input int n, input int sb,
                             input logic [14:0] ang, input logic s,
                             input logic dense);
        logic [7:0]  e [0:131];
        logic [7:0]  c;
        logic [31:0] w;
        e[2] = ang[7:0];
        e[3] = {s, ang[14:8]};
        for (int k = 0; k < (dense ? 40 : 32); k++) begin
            w = {smp[sb + k].second_predicted_sample,
                 smp[sb + k].first_predicted_sample, smp[sb + k].major};
            if (dense)
                w = {16'h0, smp[sb + k].valid ? smp[sb + k].distance_mm : 16'h0};
            for (int j = 0; j < (dense ? 2 : 4); j++)
                e[4 + k * (dense ? 2 : 4) + j] = w[8 * j +: 8];
        end
        c = 8'h00;
        for (int k = 2; k < n; k++) c = c ^ e[k];
        `ESF_CHK(host.cap[at], {4'hA, c[3:0]})
        `ESF_CHK(host.cap[at + 1], {4'h5, c[7:4]})
        `ESF_CHK(host.cap[at + 2], e[2])
        `ESF_CHK(host.cap[at + 3], e[3])
        for (int k = 4; k < n; k++)
            `ESF_CHK(host.cap[at + k], e[k])
    endtask : check_pkt

    task automatic t_regs();
        bus(1'b0, esf_pkg::CTRL_OFS, 32'h0, rd);
        `ESF_CHK(rd, esf_pkg::CTRL_RST)
        bus(1'b0, esf_pkg::RATE_OFS, 32'h0, rd);
        `ESF_CHK(rd[15:0], esf_pkg::RATE_RST)
        bus(1'b0, esf_pkg::BAUD_OFS, 32'h0, rd);
        `ESF_CHK(rd[23:0], esf_pkg::BAUD_RST)
        bus(1'b1, 8'hFC, 32'hFFFF_FFFF, rd);
        bus(1'b0, 8'hFC, 32'h0, rd);
        `ESF_CHK(rd, 32'h0000_0000)
        // 4000 * 21 fits under 115200, so dense is picked
        bus(1'b0, esf_pkg::CONF_OFS, 32'h0, rd);
        `ESF_CHK(rd[0], 1'b1)
    endtask : t_regs

    task automatic t_dense();
        plen    <= 8'h54;
        pace    <= 2'h1;
        angle_i <= {15'h1234, 1'b0};
        fill(1'b1);
        bus(1'b1, esf_pkg::CTRL_OFS, 32'h0000_0101, rd);
        fork
            begin
                feed(0, 39);
                // run drops before the last byte, so the framer idles after
                bus(1'b1, esf_pkg::CTRL_OFS, 32'h0, rd);
            end
            wait_bytes(84);
        join
        check_pkt(0, 84, 0, 15'h1234, 1'b1, 1'b1);
        bus(1'b0, esf_pkg::STATUS_OFS, 32'h0, rd);
        `ESF_CHK(rd[0], 1'b0)
        `ESF_CHK(rd[1], 1'b1)
        `ESF_CHK(rd[31:16], 16'h0001)
    endtask : t_dense

    task automatic t_legacy();
        bus(1'b1, esf_pkg::CTRL_OFS, 32'h0000_0001, rd);
        bus(1'b0, esf_pkg::STATUS_OFS, 32'h0, rd);
        `ESF_CHK(rd[2], 1'b1)
        `ESF_CHK(rd[0], 1'b0)
        bus(1'b1, esf_pkg::CTRL_OFS, 32'h0, rd);
    endtask : t_legacy

    task automatic t_ultra();
        // 16000 * 21 exceeds the link, so the compressed format is picked
        bus(1'b1, esf_pkg::RATE_OFS, 32'h0000_3E80, rd);
        bus(1'b0, esf_pkg::CONF_OFS, 32'h0, rd);
        `ESF_CHK(rd[0], 1'b0)
        plen    <= 8'h84;
        pace    <= 2'h2;
        angle_i <= {15'h5A10, 1'b0};
        fill(1'b0);
        bus(1'b1, esf_pkg::CTRL_OFS, 32'h0000_0201, rd);
        feed(0, 39);
        repeat (4) @(posedge clock_i);
        `ESF_CHK(sample_ready_o, 1'b0)
        angle_i <= {15'h0100, 1'b0};
        pace    <= 2'h1;
        fork
            feed(40, 63);
            wait_bytes(348);
        join
        check_pkt(84, 132, 0, 15'h0010, 1'b1, 1'b0);
        check_pkt(216, 132, 32, 15'h0100, 1'b0, 1'b0);
        `ESF_CHK(bad, 0)
        `ESF_CHK(good, 3)
    endtask : t_ultra

    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        t_regs();
        t_dense();
        t_legacy();
        t_ultra();
        end_of_test();
    end
endmodule : tb
